// [src/lmrt_core.sv]
// Read-telegram interpreter of the laser module: bus-slave link, answer
// builder and Avalon-MM register file with interrupt.
// Assumes SCL and SDA arrive asynchronously and the pad resolves open drain.
//
// Overview of operation
// - Op-state read uses sub address zero; the code does not check the sub address
// - Op-state codes zero to five only
// - Not ready: status, check byte, fill
// - Mode read: status, mode, check byte
// - Mode command reports driver unit mode byte
// - Mode bit 0: digital modulation enabled
// - Mode bit 1: digital input inverted
// - Mode bit 2 locked in safety variant
// - Mode bit 3: analog modulation enabled
// - Power command returns percent byte
// - Power is relative, not absolute
// - Check byte excludes device address byte
// - Power reports programmed, not measured value
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module lmrt_core
  import lmrt_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  input  wire logic        i_safety_variant,
  output logic      [3:0]  o_hw_mode,
  output logic      [7:0]  o_power_pct,
  output logic      [2:0]  o_op_state,
  output logic             o_irq
);

  function automatic logic is_read_cmd(input logic [7:0] c);
    return (c == CMD_OP_STATE) || (c == CMD_HW_MODE) || (c == CMD_POWER);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions.
  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic [1:0] safety_variant_sy_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       scl_s;
  logic       sda_s;
  logic       safety_variant;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      scl_sy_r  <= 2'h3;
      sda_sy_r  <= 2'h3;
      safety_variant_sy_r <= 2'h0;
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
    end else begin
      scl_sy_r  <= {scl_sy_r[0], i_scl};
      sda_sy_r  <= {sda_sy_r[0], i_sda};
      safety_variant_sy_r <= {safety_variant_sy_r[0], i_safety_variant};
      scl_d_r   <= scl_sy_r[1];
      sda_d_r   <= sda_sy_r[1];
    end
  end

  assign scl_s    = scl_sy_r[1];
  assign sda_s    = sda_sy_r[1];
  assign safety_variant     = safety_variant_sy_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start    = scl_s & scl_d_r & ~sda_s & sda_d_r;
  assign stop     = scl_s & scl_d_r & sda_s & ~sda_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine.
  lmrt_link_state_type st_r;
  lmrt_sys_status_type ans_stat_r;
  logic [3:0] bits_r;
  logic [7:0] sh_r;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_byte;
  logic [1:0] rx_idx_r;
  logic [1:0] tx_idx_r;
  logic       sda_oe_r;
  logic       rd_r;
  logic       mack_r;
  logic       ans_full_r;
  logic [7:0] ans_data_r;
  logic [7:0] crc_r;
  logic [7:0] crc_dat;
  logic [7:0] crc_nxt;
  logic       byte_end;
  logic       addr_hit;
  logic       rx_done;
  logic       tx_load;
  logic       crc_upd_tx;

  assign byte_end = scl_fall && (bits_r == BYTE_BITS);
  assign addr_hit = (st_r == L_ADDR) && byte_end && (sh_r[7:1] == I2C_DEV_ADDR);
  assign rx_done  = (st_r == L_RX) && byte_end;
  assign tx_load  = scl_fall && (((st_r == L_AACK) && rd_r) || ((st_r == L_TACK) && mack_r));

  // The answer is frozen when the read address is taken, so a state change
  // during the transfer cannot split status and check byte.
  always_comb begin
    case (tx_idx_r)
      2'h0:    tx_byte = ans_stat_r;
      2'h1:    tx_byte = ans_full_r ? ans_data_r : crc_r;
      2'h2:    tx_byte = ans_full_r ? crc_r : FILL_BYTE;
      default: tx_byte = FILL_BYTE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_r     <= L_IDLE;
      bits_r   <= 4'h0;
      sh_r     <= 8'h00;
      tx_sh_r  <= 8'h00;
      sda_oe_r <= 1'b0;
      rd_r     <= 1'b0;
      mack_r   <= 1'b0;
      rx_idx_r <= 2'h0;
      tx_idx_r <= 2'h0;
    end else if (start) begin
      st_r     <= L_ADDR;
      bits_r   <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop) begin
      st_r     <= L_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        L_ADDR, L_RX: begin
          if (scl_rise) begin
            sh_r   <= {sh_r[6:0], sda_s};
            bits_r <= 4'(bits_r + 4'h1);
          end else if (rx_done || addr_hit) begin
            st_r     <= (st_r == L_RX) ? L_RACK : L_AACK;
            sda_oe_r <= 1'b1;
          end else if (byte_end) begin
            st_r <= L_IDLE;
          end
          if (addr_hit) begin
            rd_r     <= sh_r[0];
            rx_idx_r <= 2'h0;
            tx_idx_r <= 2'h0;
          end
          if (rx_done && rx_idx_r != IDX_SAT) begin
            rx_idx_r <= 2'(rx_idx_r + 2'h1);
          end
        end
        L_AACK, L_RACK: begin
          if (scl_fall) begin
            st_r     <= L_RX;
            bits_r   <= 4'h0;
            sda_oe_r <= 1'b0;
          end
        end
        L_TX: begin
          if (byte_end) begin
            st_r     <= L_TACK;
            sda_oe_r <= 1'b0;
          end else if (scl_fall) begin
            sda_oe_r <= ~tx_sh_r[7];
            tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
            bits_r   <= 4'(bits_r + 4'h1);
          end
        end
        L_TACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s;
          end else if (scl_fall && !mack_r) begin
            st_r <= L_IDLE;
          end
        end
        default: begin
        end
      endcase
      if (tx_load) begin
        st_r     <= L_TX;
        sda_oe_r <= ~tx_byte[7];
        tx_sh_r  <= {tx_byte[6:0], 1'b0};
        bits_r   <= 4'h1;
        if (tx_idx_r != IDX_SAT) begin
          tx_idx_r <= 2'(tx_idx_r + 2'h1);
        end
      end
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Check byte: restarted at every start, so the address byte never enters.
  assign crc_upd_tx = tx_load && ((tx_idx_r == 2'h0) || ((tx_idx_r == 2'h1) && ans_full_r));
  assign crc_dat    = (st_r == L_RX) ? sh_r : tx_byte;

  lmrt_crc8 u_crc (
    .i_crc  (crc_r),
    .i_data (crc_dat),
    .o_crc  (crc_nxt)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn || start) begin
      crc_r <= CRC_INIT;
    end else if ((rx_done && rx_idx_r < TGM_LAST) || crc_upd_tx) begin
      crc_r <= crc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Telegram interpretation and answer readiness.
  logic [7:0] cmd_rx_r;
  logic [7:0] pend_cmd_r;
  logic [7:0] busy_cnt_r;
  logic       have_cmd_r;
  logic       tel_err_r;
  logic       nack_r;
  logic       tgm_done;
  logic       tgm_ok;
  logic       premature;
  logic       ready;
  logic [2:0] op_state_r;
  logic [7:0] power_r;
  lmrt_hw_mode_type    mode_r;
  lmrt_warn_type       warn_r;
  lmrt_sys_status_type stat_now;
  logic [7:0]          data_now;

  assign tgm_done  = rx_done && (rx_idx_r == TGM_LAST);
  assign tgm_ok    = tgm_done && (sh_r == crc_r);
  assign premature = stop && !rd_r && (st_r == L_RX || st_r == L_RACK)
                     && rx_idx_r != 2'h0 && rx_idx_r != IDX_SAT;
  assign ready     = have_cmd_r && (busy_cnt_r == 8'h00);

  // The sub address only feeds the check byte; only one master unit exists.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cmd_rx_r <= 8'h00;
    end else if (rx_done && rx_idx_r == 2'h0) begin
      cmd_rx_r <= sh_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pend_cmd_r <= 8'h00;
      have_cmd_r <= 1'b0;
      busy_cnt_r <= 8'h00;
      tel_err_r  <= 1'b0;
      nack_r     <= 1'b0;
    end else if (tgm_done) begin
      if (!tgm_ok) begin
        tel_err_r <= 1'b1;
      end else if (is_read_cmd(cmd_rx_r)) begin
        pend_cmd_r <= cmd_rx_r;
        have_cmd_r <= 1'b1;
        busy_cnt_r <= RESP_CNT;
        tel_err_r  <= 1'b0;
        nack_r     <= 1'b0;
      end else begin
        tel_err_r <= 1'b0;
        nack_r    <= 1'b1;
      end
    end else begin
      if (premature) begin
        nack_r <= 1'b1;
      end
      if (busy_cnt_r != 8'h00) begin
        busy_cnt_r <= 8'(busy_cnt_r - 8'h01);
      end
    end
  end

  always_comb begin
    stat_now         = '0;
    stat_now.busy    = busy_cnt_r != 8'h00;
    stat_now.tel_err = tel_err_r;
    stat_now.nack    = nack_r;
    stat_now.warn2   = warn_r.warn2;
    stat_now.warn1   = warn_r.warn1;
    stat_now.sys_err = warn_r.sys_err;
    case (pend_cmd_r)
      CMD_OP_STATE: data_now = {5'h00, op_state_r};
      CMD_HW_MODE:  data_now = {4'h0, mode_r};
      CMD_POWER:    data_now = power_r;
      default:      data_now = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ans_stat_r <= '0;
      ans_full_r <= 1'b0;
      ans_data_r <= 8'h00;
    end else if (addr_hit && sh_r[0]) begin
      ans_stat_r <= stat_now;
      ans_full_r <= ready;
      ans_data_r <= data_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: every access is answered on its second edge.
  logic        ack_r;
  logic        req;
  logic        wr_en;
  logic        rd_clr;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_ev;
  lmrt_link_stat_type link_stat;

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_r;
  assign wr_en             = i_avs_write & ack_r & i_avs_byteenable[0];
  assign rd_clr            = i_avs_read & ack_r & (i_avs_address == OFF_IRQ_STAT);
  assign link_stat         = '{nack: nack_r, tel_err: tel_err_r, ready: ready, cmd: pend_cmd_r};

  always_comb begin
    case (i_avs_address)
      OFF_OP_STATE:  rd_mux = 32'(op_state_r);
      OFF_HW_MODE:   rd_mux = 32'(mode_r);
      OFF_POWER:     rd_mux = 32'(power_r);
      OFF_WARN:      rd_mux = 32'(warn_r);
      OFF_LINK_STAT: rd_mux = 32'(link_stat);
      OFF_IRQ_STAT:  rd_mux = 32'(irq_stat_r);
      OFF_IRQ_MASK:  rd_mux = 32'(irq_mask_r);
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (i_avs_read && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign o_avs_readdata = rdata_r;

  // Out-of-range state codes are dropped rather than clipped, so software
  // never sees a state it did not ask for.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      op_state_r <= RST_OP_STATE;
      mode_r     <= RST_HW_MODE;
      power_r    <= RST_POWER;
      warn_r     <= '0;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      case (i_avs_address)
        OFF_OP_STATE: begin
          if (i_avs_writedata[2:0] <= ST_SLEEP) begin
            op_state_r <= i_avs_writedata[2:0];
          end
        end
        OFF_HW_MODE: begin
          mode_r.dig_en     <= i_avs_writedata[0];
          mode_r.dig_invert <= i_avs_writedata[1];
          mode_r.analog_en  <= i_avs_writedata[3];
          if (!safety_variant) begin
            mode_r.sys_en_honour <= i_avs_writedata[2];
          end
        end
        OFF_POWER:     power_r    <= i_avs_writedata[7:0];
        OFF_WARN:      warn_r     <= i_avs_writedata[2:0];
        OFF_IRQ_MASK:  irq_mask_r <= i_avs_writedata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  assign o_op_state  = op_state_r;
  assign o_hw_mode   = mode_r;
  assign o_power_pct = power_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: a new event wins over a clearing read in the same cycle.
  always_comb begin
    irq_ev              = '0;
    irq_ev[IRQ_TGM_OK]  = tgm_ok;
    irq_ev[IRQ_TGM_ERR] = tgm_done & ~tgm_ok;
    irq_ev[IRQ_ANSWER]  = addr_hit & sh_r[0];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (rd_clr ? '0 : irq_stat_r) | irq_ev;
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  logic snap;
  assign snap = addr_hit && sh_r[0] && ready;

  a_op_state_legal: assert property (op_state_r <= ST_SLEEP)
    else $error("operating state code out of range");
  a_opstate_answer: assert property (snap && pend_cmd_r == CMD_OP_STATE
    |=> ans_data_r == {5'h00, $past(op_state_r)} && ans_full_r)
    else $error("operating state answer wrong");
  a_mode_answer: assert property (snap && pend_cmd_r == CMD_HW_MODE
    |=> ans_data_r[3:0] == $past(mode_r) && ans_data_r[7:4] == 4'h0)
    else $error("mode answer wrong");
  a_power_answer: assert property (snap && pend_cmd_r == CMD_POWER
    |=> ans_data_r == $past(power_r))
    else $error("power answer wrong");
  a_safety_lock: assert property (safety_variant && wr_en && i_avs_address == OFF_HW_MODE
    |=> mode_r.sys_en_honour == $past(mode_r.sys_en_honour))
    else $error("locked mode bit changed");
  a_unready_fill: assert property (tx_load && !ans_full_r && tx_idx_r == 2'h1
    |-> tx_byte == crc_r ##1 (tx_idx_r == TGM_LAST && tx_byte == FILL_BYTE))
    else $error("unready answer not status, check, fill");
  a_bad_crc_drop: assert property (tgm_done && !tgm_ok
    |=> tel_err_r && $stable(pend_cmd_r) && irq_stat_r[IRQ_TGM_ERR])
    else $error("bad telegram not discarded");
  a_busy_window: assert property (tgm_ok && is_read_cmd(cmd_rx_r)
    |=> busy_cnt_r == RESP_CNT ##1 busy_cnt_r == 8'(RESP_CNT - 8'h01))
    else $error("answer latency count wrong");
  a_avs_answer: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus access not answered on second edge");

endmodule
`default_nettype wire

// [src/lmrt_pkg.sv]
// Constants, field layouts and types of the laser module read-telegram block.
// Assumes a 125 MHz core clock and 32-bit Avalon-MM register words.
package lmrt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Telegram commands and answer bytes.
  localparam logic [7:0] CMD_OP_STATE = 8'h84;
  localparam logic [7:0] CMD_HW_MODE  = 8'h14;
  localparam logic [7:0] CMD_POWER    = 8'h4e;
  localparam logic [7:0] FILL_BYTE    = 8'hff;
  localparam logic [7:0] CRC_INIT     = 8'h00;
  localparam logic [7:0] CRC_POLY     = 8'h07;
  // Bus device address; the value is arbitrary.
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2a;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [1:0] TGM_LAST     = 2'h2;
  localparam logic [1:0] IDX_SAT      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Operating state codes.
  localparam logic [2:0] ST_BOOT        = 3'h0;
  localparam logic [2:0] ST_IDLE_WAIT   = 3'h1;
  localparam logic [2:0] ST_OPERATIONAL = 3'h2;
  localparam logic [2:0] ST_MAINTENANCE = 3'h3;
  localparam logic [2:0] ST_FAULT       = 3'h4;
  localparam logic [2:0] ST_SLEEP       = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Answer latency after an accepted telegram.
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         RESP_TIME_NS  = 1000;
  localparam int         RESP_CYCLES   = (RESP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESP_CNT      = 8'(RESP_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets and reset values.
  localparam logic [4:0] OFF_OP_STATE  = 5'h00;
  localparam logic [4:0] OFF_HW_MODE   = 5'h04;
  localparam logic [4:0] OFF_POWER     = 5'h08;
  localparam logic [4:0] OFF_WARN      = 5'h0c;
  localparam logic [4:0] OFF_LINK_STAT = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT  = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK  = 5'h18;
  localparam logic [2:0] RST_OP_STATE  = 3'h0;
  localparam logic [3:0] RST_HW_MODE   = 4'h4;
  localparam logic [7:0] RST_POWER     = 8'h00;
  localparam int         IRQ_W         = 3;
  localparam int         IRQ_TGM_OK    = 0;
  localparam int         IRQ_TGM_ERR   = 1;
  localparam int         IRQ_ANSWER    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Field layouts.
  typedef struct packed {
    logic sys_err;
    logic rsvd6;
    logic warn1;
    logic warn2;
    logic nack;
    logic rsvd2;
    logic tel_err;
    logic busy;
  } lmrt_sys_status_type;

  typedef struct packed {
    logic analog_en;
    logic sys_en_honour;
    logic dig_invert;
    logic dig_en;
  } lmrt_hw_mode_type;

  typedef struct packed {
    logic sys_err;
    logic warn1;
    logic warn2;
  } lmrt_warn_type;

  typedef struct packed {
    logic       nack;
    logic       tel_err;
    logic       ready;
    logic [7:0] cmd;
  } lmrt_link_stat_type;

  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_AACK, L_RX, L_RACK, L_TX, L_TACK
  } lmrt_link_state_type;

endpackage

// [src/lmrt_crc8.sv]
// One byte step of the telegram check byte, MSB first.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/1ns
`default_nettype none
module lmrt_crc8
  import lmrt_pkg::*;
(
  input  wire logic [7:0] i_crc,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_crc
);

  logic [7:0] c;

  always_comb begin
    c = i_crc ^ i_data;
    for (int k = 0; k < 8; k++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    o_crc = c;
  end

endmodule
`default_nettype wire

// [sim/lmrt_i2c_host.sv]
// I2C host model: sends command telegrams and reads the answers back.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module lmrt_i2c_host
  import lmrt_pkg::*;
(
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // SCL stands high between frames; 62/63 ns phases give a 125 ns bit, unrelated to the core clock.
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    return r;
  endfunction

  task automatic bit_io(input logic b, output logic r);
    #31 o_sda_low = ~b;
    #31 o_scl = 1'b1;
    #32 r = i_sda;
    #31 o_scl = 1'b0;
  endtask

  task automatic start_c();
    #31 o_sda_low = 1'b0;
    #31 o_scl = 1'b1;
    #63 o_sda_low = 1'b1;
    #31 o_scl = 1'b0;
  endtask

  task automatic stop_c();
    #31 o_sda_low = 1'b1;
    #31 o_scl = 1'b1;
    #63 o_sda_low = 1'b0;
    #63;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // The check byte covers command and sub address; bad flips its low bit on purpose.
  task automatic send(input logic [7:0] cmd, input logic [7:0] sub, input logic bad, output logic ok);
    logic a;
    logic [7:0] c;
    c = crc8(crc8(CRC_INIT, cmd), sub) ^ {7'h00, bad};
    start_c();
    wbyte({I2C_DEV_ADDR, 1'b0}, ok);
    wbyte(cmd, a);
    ok = ok & a;
    wbyte(sub, a);
    ok = ok & a;
    wbyte(c, a);
    ok = ok & a;
    stop_c();
  endtask

  task automatic fetch(output logic [7:0] q [4]);
    logic a;
    start_c();
    wbyte({I2C_DEV_ADDR, 1'b1}, a);
    for (int k = 0; k < 4; k++) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, q[k][i]);
      bit_io(k == 3, a);
    end
    stop_c();
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Bench for the read-telegram block: Avalon-MM register tasks and I2C telegrams.
// Assumes lmrt_i2c_host on the link and a pull-up on SDA.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import lmrt_pkg::*;
;
  logic        clk;
  logic        rstn;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_req;
  logic        scl;
  logic        sda_low;
  logic        dut_oe;
  logic        dut_o;
  logic        safety;
  logic [3:0]  hw_mode;
  logic [7:0]  power;
  logic [2:0]  op_state;
  logic        irq;
  logic        ok;
  logic [31:0] d;
  logic [7:0]  ans [4];
  logic [2:0]  warn;
  int          fail_count;
  int          cmp_count;
  int          cyc;
  wire logic   sda;

  // The pad pulls low only while enabled and driving zero, so a wrong data level shows up.
  assign sda = ~(sda_low | (dut_oe & ~dut_o));

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    addr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    safety = 1'b0;
    warn = 3'h0;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
  end
  always #4 clk = ~clk;

  lmrt_core i_dut (.i_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'h1), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .i_scl(scl), .i_sda(sda), .o_sda_o(dut_o), .o_sda_oe(dut_oe), .i_safety_variant(safety),
    .o_hw_mode(hw_mode), .o_power_pct(power), .o_op_state(op_state), .o_irq(irq));
  lmrt_i2c_host i_host (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Requests are held until waitrequest is sampled low at a rising edge.
  task automatic av_acc(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clk);
    addr  <= a;
    wdata <= wd;
    wr    <= w;
    rd    <= ~w;
    do @(posedge clk); while (wait_req !== 1'b0);
    d = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic av_chk(input logic [4:0] a, input logic [31:0] exp);
    av_acc(1'b0, a, 32'h0);
    chk(d, exp);
  endtask

  // Reads again while busy, since a busy answer carries no data.
  task automatic tgm(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] st;
    st = {warn[2], 1'b0, warn[1], warn[0], 4'h0};
    i_host.send(cmd, 8'h00, 1'b0, ok);
    chk(ok, 32'h1);
    i_host.fetch(ans);
    for (int t = 0; t < 3 && ans[0][0] !== 1'b0; t++) i_host.fetch(ans);
    chk(ans[0], st);
    chk(ans[1], exp);
    chk(ans[2], i_host.crc8(i_host.crc8(CRC_INIT, st), exp));
    chk(ans[3], FILL_BYTE);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    av_chk(OFF_OP_STATE, 32'h0);
    av_chk(OFF_HW_MODE, 32'h4);
    av_chk(OFF_POWER, 32'h0);
    av_chk(OFF_IRQ_MASK, 32'h0);
    av_chk(5'h1c, 32'h0);
    i_host.fetch(ans);
    chk(ans[0], 32'h0);
    chk(ans[1], 32'h0);
    chk(ans[2], FILL_BYTE);
    $display("test reset_and_not_ready done");
    warn = 3'h1;
    av_acc(1'b1, OFF_WARN, 32'h1);
    for (int s = 0; s < 6; s++) begin
      av_acc(1'b1, OFF_OP_STATE, 32'(s));
      tgm(CMD_OP_STATE, 8'(s));
      chk(op_state, 32'(s));
    end
    av_acc(1'b1, OFF_OP_STATE, 32'h6);
    av_chk(OFF_OP_STATE, 32'h5);
    $display("test op_state done");
    for (int k = 0; k < 4; k++) begin
      av_acc(1'b1, OFF_HW_MODE, 32'(1 << k));
      tgm(CMD_HW_MODE, 8'(1 << k));
      chk(hw_mode, 32'(1 << k));
    end
    @(posedge clk);
    safety <= 1'b1;
    repeat (4) @(posedge clk);
    av_acc(1'b1, OFF_HW_MODE, 32'hf);
    av_chk(OFF_HW_MODE, 32'hb);
    tgm(CMD_HW_MODE, 8'h0b);
    @(posedge clk);
    safety <= 1'b0;
    $display("test hw_mode done");
    av_acc(1'b1, OFF_POWER, 32'h64);
    tgm(CMD_POWER, 8'h64);
    chk(power, 32'h64);
    $display("test power done");
    av_acc(1'b0, OFF_IRQ_STAT, 32'h0);
    i_host.send(CMD_POWER, 8'h00, 1'b0, ok);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    av_acc(1'b1, OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 32'h1);
    av_chk(OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    $display("test irq done");
    i_host.send(CMD_HW_MODE, 8'h00, 1'b1, ok);
    i_host.fetch(ans);
    chk(ans[0][1], 32'h1);
    chk(ans[1], 32'h64);
    av_chk(OFF_IRQ_STAT, 32'h6);
    // A well-formed telegram with an unknown command is refused with the nack flag.
    i_host.send(8'h5a, 8'h00, 1'b0, ok);
    i_host.fetch(ans);
    chk(ans[0], 32'h18);
    av_chk(OFF_LINK_STAT, 32'h54e);
    tgm(CMD_POWER, 8'h64);
    $display("test bad_check_byte done");
    print_verdict();
  end
endmodule
`default_nettype wire
